// file: hw/seaw_regs.svh
// constants for the serial eeprom address and write control block
// assumes a 200 MHz core clock; included by the controller and the property checker
`ifndef SEAW_REGS_SVH
`define SEAW_REGS_SVH
`define SEAW_CLK_PERIOD_NS 5
`define SEAW_WRITE_CYCLE_TIME_NS 5000000
`define SEAW_WRITE_CYCLE_CYCLES \
	(`SEAW_WRITE_CYCLE_TIME_NS / `SEAW_CLK_PERIOD_NS)
`define SEAW_PAGE_COUNT 512
`define SEAW_PAGE_BYTES 256
`define SEAW_ADDR_W 17
`define SEAW_TYPE_HI 7
`define SEAW_TYPE_LO 4
`define SEAW_STRAP_HI_BIT 3
`define SEAW_STRAP_LO_BIT 2
`define SEAW_MSB_BIT 1
`define SEAW_RW_BIT 0
`define SEAW_FIFO_DEPTH 8
`define SEAW_FIFO_WIDTH 25
`endif

// file: hw/seaw_pkg.sv
// types shared by the serial eeprom address and write control block
// assumes seaw_regs.svh constants
package seaw_pkg;
	typedef enum logic [3:0] {
		SEAW_IDLE,
		SEAW_DEV,
		SEAW_DEV_ACK,
		SEAW_WA1,
		SEAW_WA1_ACK,
		SEAW_WA2,
		SEAW_WA2_ACK,
		SEAW_DATA,
		SEAW_DATA_ACK,
		SEAW_IGNORE
	} seaw_state_t;
endpackage

// file: hw/seaw_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes one clock, synchronous active high reset and a clock enable
`timescale 1ns/1ps
module seaw_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || (clk_en && flush)) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// registered read data, valid while not empty
	always_ff @(posedge clk) begin
		if (reset || (clk_en && flush)) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (clk_en) begin
			if (!out_valid || out_ready) begin
				out_valid <= (count_r != '0) && !(pop && count_r == 1);
				out_data <= pop ? mem_r[rd_ptr_r + 1'b1] : mem_r[rd_ptr_r];
			end
		end
	end
endmodule

// file: hw/seaw_ctrl.sv
// address decode and write control of a two-wire serial eeprom slave
// assumes bus pins arrive asynchronously; array port is a plain handshake
`timescale 1ns/1ps
`include "seaw_regs.svh"
module seaw_ctrl import seaw_pkg::*; #(
	parameter int WRITE_CYCLE_CYCLES = `SEAW_WRITE_CYCLE_CYCLES,
	parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary neutral value
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic address_strap_high,
	input wire logic address_strap_low,
	input wire logic write_protect_input,
	output logic [`SEAW_ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic wr_commit,
	output logic wr_busy,
	output logic rd_start,
	output logic [`SEAW_ADDR_W-1:0] cur_addr
);
	////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [1:0] scl_s1_r, scl_s2_r;
	logic scl_d_r, sda_d_r;
	logic [1:0] strap_s1_r, strap_s2_r;
	logic wp_s1_r, wp_s2_r;

	// bus pins idle high, so the stages reset high to avoid false edges
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_s1_r <= 2'h3;
			scl_s2_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (clk_en) begin
			scl_s1_r <= {sda_in, scl_in};
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r[0];
			sda_d_r <= scl_s2_r[1];
		end
	end

	// floating straps read as zero
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
		end else if (clk_en) begin
			strap_s1_r <= {address_strap_high, address_strap_low};
			strap_s2_r <= strap_s1_r;
		end
	end

	// unconnected protect input reads as unprotected
	always_ff @(posedge clk) begin
		if (reset) begin
			wp_s1_r <= 1'b0;
			wp_s2_r <= 1'b0;
		end else if (clk_en) begin
			wp_s1_r <= write_protect_input;
			wp_s2_r <= wp_s1_r;
		end
	end

	logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
	assign scl = scl_s2_r[0];
	assign sda = scl_s2_r[1];
	assign scl_rise = scl && !scl_d_r;
	assign scl_fall = !scl && scl_d_r;
	assign start_ev = scl && scl_d_r && sda_d_r && !sda;
	assign stop_ev = scl && scl_d_r && !sda_d_r && sda;

	////////////////////////////////////////////////////////////////////
	// bit shifter and byte framing
	seaw_state_t state_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic busy_r;
	logic [$clog2(WRITE_CYCLE_CYCLES+1)-1:0] wc_cnt_r;
	logic [`SEAW_ADDR_W-1:0] addr_r;
	logic is_write_r, have_data_r, ack_r;
	logic [7:0] rx_byte;
	logic byte_done, dev_match;

	// msb first, eight bits then ack
	assign rx_byte = {shift_r[6:0], sda};
	assign byte_done = scl_rise && bit_cnt_r == 4'h7;
	assign dev_match =
		rx_byte[`SEAW_TYPE_HI:`SEAW_TYPE_LO] == TYPE_CODE &&
		rx_byte[`SEAW_STRAP_HI_BIT] == strap_s2_r[1] &&
		rx_byte[`SEAW_STRAP_LO_BIT] == strap_s2_r[0];

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_r <= 8'h00;
			bit_cnt_r <= 4'h0;
		end else if (clk_en) begin
			if (start_ev || stop_ev) begin
				bit_cnt_r <= 4'h0;
			end else if (scl_rise) begin
				shift_r <= rx_byte;
				bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// protocol state machine
	logic fifo_in_ready;
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= SEAW_IDLE;
			ack_r <= 1'b0;
		end else if (clk_en) begin
			if (stop_ev) begin
				state_r <= SEAW_IDLE;
			end else if (start_ev) begin
				// bus ignored while busy, polls nacked
				state_r <= SEAW_DEV;
			end else begin
				unique case (state_r)
				SEAW_IDLE, SEAW_IGNORE: begin
				end
				SEAW_DEV: if (byte_done) begin
					// ack only a match and only when idle
					ack_r <= dev_match && !busy_r;
					state_r <= SEAW_DEV_ACK;
				end
				SEAW_DEV_ACK: if (scl_fall && bit_cnt_r == 4'h0) begin
					// reads handed off, writes take address
					if (!ack_r || !is_write_r) begin
						state_r <= SEAW_IGNORE;
					end else begin
						state_r <= SEAW_WA1;
					end
				end
				SEAW_WA1: if (byte_done) begin
					state_r <= SEAW_WA1_ACK;
				end
				SEAW_WA1_ACK: if (scl_fall && bit_cnt_r == 4'h0) begin
					state_r <= SEAW_WA2;
				end
				SEAW_WA2: if (byte_done) begin
					state_r <= SEAW_WA2_ACK;
				end
				SEAW_WA2_ACK, SEAW_DATA_ACK:
				if (scl_fall && bit_cnt_r == 4'h0) begin
					state_r <= SEAW_DATA;
				end
				SEAW_DATA: if (byte_done) begin
					// nack the data byte while array buffer is full
					ack_r <= fifo_in_ready;
					state_r <= SEAW_DATA_ACK;
				end
				endcase
			end
		end
	end

	// ack drive falls into the ninth bit on the falling edge
	always_ff @(posedge clk) begin
		if (reset) begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end else if (clk_en) begin
			if (start_ev || stop_ev) begin
				sda_oe <= 1'b0;
			end else if (scl_fall) begin
				sda_out <= 1'b0;
				sda_oe <= bit_cnt_r == 4'h8 && (
					(state_r == SEAW_DEV_ACK && ack_r) ||
					state_r == SEAW_WA1_ACK ||
					state_r == SEAW_WA2_ACK ||
					(state_r == SEAW_DATA_ACK && ack_r));
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// address register and operation flags
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_r <= '0;
			is_write_r <= 1'b0;
			have_data_r <= 1'b0;
		end else if (clk_en) begin
			if (start_ev) begin
				have_data_r <= 1'b0;
			end
			if (byte_done && !start_ev && !stop_ev) begin
				unique case (state_r)
				SEAW_DEV: if (dev_match && !busy_r) begin
					addr_r[16] <= rx_byte[`SEAW_MSB_BIT];
					is_write_r <= !rx_byte[`SEAW_RW_BIT];
				end
				SEAW_WA1: addr_r[15:8] <= rx_byte;
				SEAW_WA2: addr_r[7:0] <= rx_byte;
				SEAW_DATA: if (fifo_in_ready) begin
					// low byte wraps inside the page
					addr_r[7:0] <= addr_r[7:0] + 8'h01;
					have_data_r <= 1'b1;
				end
				default: begin
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// write data buffer towards the array
	logic fifo_push;
	logic [`SEAW_FIFO_WIDTH-1:0] fifo_out;
	logic fifo_out_valid, fifo_flush, commit_ev;
	// row fixed, byte address seventeen bits
	assign fifo_push = state_r == SEAW_DATA && byte_done &&
		!start_ev && !stop_ev;
	// stop after data starts cycle unless protected
	assign commit_ev = stop_ev && have_data_r && !busy_r;
	// protected or aborted data is dropped
	assign fifo_flush = (commit_ev && wp_s2_r) ||
		(start_ev && !busy_r);

	seaw_fifo #(
		.WIDTH(`SEAW_FIFO_WIDTH),
		.DEPTH(`SEAW_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.flush(fifo_flush),
		.in_data({addr_r, rx_byte}),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(wr_ready && busy_r)
	);

	// one pulse per byte popped from the buffer
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_valid <= 1'b0;
		end else if (clk_en) begin
			wr_valid <= fifo_out_valid && busy_r && wr_ready;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_addr <= '0;
			wr_data <= 8'h00;
		end else if (clk_en) begin
			wr_addr <= fifo_out[24:8];
			wr_data <= fifo_out[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// self-timed write cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_r <= 1'b0;
			wc_cnt_r <= '0;
			wr_commit <= 1'b0;
		end else if (clk_en) begin
			wr_commit <= 1'b0;
			if (commit_ev && !wp_s2_r) begin
				busy_r <= 1'b1;
				wc_cnt_r <= ($bits(wc_cnt_r))'(WRITE_CYCLE_CYCLES);
				wr_commit <= 1'b1;
			end else if (busy_r) begin
				if (wc_cnt_r <= 1 && !fifo_out_valid) begin
					busy_r <= 1'b0;
				end
				if (wc_cnt_r != '0) begin
					wc_cnt_r <= wc_cnt_r - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_busy <= 1'b0;
		end else if (clk_en) begin
			wr_busy <= busy_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cur_addr <= '0;
		end else if (clk_en) begin
			cur_addr <= addr_r;
		end
	end

	// read path lives outside; flag an acked read address
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_start <= 1'b0;
		end else if (clk_en) begin
			rd_start <= state_r == SEAW_DEV_ACK && scl_fall &&
				bit_cnt_r == 4'h0 && ack_r && !is_write_r;
		end
	end
endmodule

// file: test/seaw_ctrl_properties.sv
// port checker for the eeprom address and write control block
// assumes it is bound to seaw_ctrl with the same write cycle count
`timescale 1ns/1ps
`include "seaw_regs.svh"
module seaw_ctrl_props #(
	parameter int WCC = 400
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [`SEAW_ADDR_W-1:0] wr_addr,
	input wire logic wr_valid,
	input wire logic wr_commit,
	input wire logic wr_busy
);
	logic [15:0] bc_r;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// counts cycles of the running write cycle
	always_ff @(posedge clk) begin
		if (reset || !wr_busy) begin
			bc_r <= 16'h0;
		end else begin
			bc_r <= bc_r + 16'h1;
		end
	end
	commit_to_busy_a: assert property (wr_commit |=> wr_busy)
		else $error("busy did not follow commit");
	commit_pulse_a: assert property (wr_commit |=> !wr_commit)
		else $error("commit longer than one cycle");
	commit_idle_a: assert property (wr_commit |-> !wr_busy)
		else $error("commit while busy");
	valid_in_busy_a: assert property (wr_valid |-> wr_busy)
		else $error("array write outside write cycle");
	busy_hold_a: assert property ($rose(wr_busy) |-> wr_busy [*8])
		else $error("write cycle too short");
	busy_max_a: assert property (bc_r <= WCC + 4)
		else $error("write cycle too long");
	busy_min_a: assert property ($fell(wr_busy) |-> bc_r >= WCC - 4)
		else $error("write cycle ended early");
	quiet_busy_a: assert property (wr_busy [*2] |-> !sda_oe)
		else $error("acknowledge during write cycle");
	oe_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data driven while clock high");
	drain_low_a: assert property (sda_oe |-> !sda_out)
		else $error("driven data not low");
	row_fixed_a: assert property (wr_valid && $past(wr_valid) |->
		wr_addr[16:8] == $past(wr_addr[16:8]))
		else $error("page row changed within write");
endmodule

// file: test/seaw_master.sv
// two-wire bus master model driving clock and open-drain data
// assumes the device's data enable is fed back to resolve the wire
`timescale 1ns/1ps
module seaw_master (
	output logic scl,
	output logic sda,
	input wire logic dev_oe
);
	localparam real Q = 31.25;
	logic drv;
	// pulled-up wire, low while either party pulls
	assign sda = drv & ~dev_oe;
	initial begin
		scl = 1'b1;
		drv = 1'b1;
	end
	// start or repeated start, clock idles high
	task automatic start();
		#Q drv = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) drv = 1'b0;
		#(2*Q) scl = 1'b0;
	endtask
	// msb first, ninth bit released for acknowledge
	task automatic bits(input logic [8:0] v, output logic nak);
		for (int i = 8; i >= 0; i--) begin
			#Q drv = v[i];
			#Q scl = 1'b1;
			#Q nak = sda;
			#Q scl = 1'b0;
		end
	endtask
	task automatic stop();
		#Q drv = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) drv = 1'b1;
		#(2*Q);
	endtask
endmodule

// file: test/seaw_ctrl_tb.sv
// testbench for the eeprom address and write control block
// assumes master model and checker are compiled first
`timescale 1ns/1ps
module seaw_ctrl_tb;
	localparam int WCC = 400;
	localparam logic [3:0] TC = 4'h5;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic strap_h = 1'b0;
	logic strap_l = 1'b0;
	logic wp = 1'b0;
	logic wr_ready = 1'b1;
	logic scl, sda, sda_out, sda_oe, wr_valid, wr_commit, wr_busy, rd_start;
	logic [16:0] wr_addr, cur_addr;
	logic [7:0] wr_data;
	logic [24:0] got[$];
	int err_count = 0;
	int cmp_count = 0;
	int commits = 0;
	int reads = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (wr_valid === 1'b1)
			got.push_back({wr_addr, wr_data});
		if (wr_commit === 1'b1)
			commits++;
		if (rd_start === 1'b1)
			reads++;
	end
	seaw_ctrl #(.WRITE_CYCLE_CYCLES(WCC), .TYPE_CODE(TC)) u_dut (
		.clk(clk), .reset(reset), .clk_en(1'b1), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_strap_high(strap_h), .address_strap_low(strap_l),
		.write_protect_input(wp), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_commit(wr_commit),
		.wr_busy(wr_busy), .rd_start(rd_start), .cur_addr(cur_addr));
	seaw_master u_mst (.scl(scl), .sda(sda), .dev_oe(sda_oe));
	task automatic chk(input string what, input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	// device byte, then n bytes: two address bytes and data d0+index
	task automatic frame(input logic [7:0] dev, input logic [15:0] wa,
		input int n, input logic [7:0] d0, output logic [11:0] nk);
		logic [7:0] b;
		nk = '0;
		u_mst.start();
		u_mst.bits({dev, 1'b1}, nk[0]);
		for (int i = 0; i < n; i++) begin
			b = (i == 0) ? wa[15:8] : (i == 1) ? wa[7:0] : d0 + 8'(i);
			u_mst.bits({b, 1'b1}, nk[i+1]);
		end
		u_mst.stop();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < WCC + 100 && wr_busy !== 1'b0; i++)
			@(posedge clk);
	endtask
	task automatic t_decode();
		logic [11:0] nk;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			strap_h <= s[1];
			strap_l <= s[0];
			repeat (4) @(posedge clk);
			frame({TC, s[1:0], 2'b01}, 16'h0, 0, 8'h0, nk);
			chk("match ack", nk[0], 1'b0);
			frame({TC, ~s[1:0], 2'b01}, 16'h0, 0, 8'h0, nk);
			chk("strap nack", nk[0], 1'b1);
		end
		frame({~TC, 4'b1101}, 16'h0, 0, 8'h0, nk);
		chk("type nack", nk[0], 1'b1);
		chk("read starts", reads, 4);
		chk("no commit", commits, 0);
	endtask
	task automatic t_byte();
		logic [11:0] nk;
		frame({TC, 4'b1110}, 16'h1234, 3, 8'h40, nk);
		chk("byte acks", nk[3:0], 4'h0);
		chk("commit", commits, 1);
		@(posedge clk);
		wp <= 1'b1;
		frame({TC, 4'b1110}, 16'h0, 0, 8'h0, nk);
		chk("busy poll", nk[0], 1'b1);
		chk("busy held", wr_busy, 1'b1);
		wait_idle();
		chk("busy end", wr_busy, 1'b0);
		chk("byte", got.pop_front(), {17'h11234, 8'h42});
		frame({TC, 4'b1110}, 16'h0, 0, 8'h0, nk);
		chk("idle poll", nk[0], 1'b0);
		chk("cur addr", cur_addr, 17'h11235);
		@(posedge clk);
		wp <= 1'b0;
	endtask
	task automatic t_page();
		logic [11:0] nk;
		@(posedge clk);
		wr_ready <= 1'b0;
		frame({TC, 4'b1100}, 16'h07fe, 11, 8'h10, nk);
		chk("page acks", nk, 12'h800);
		repeat (20) @(posedge clk);
		chk("stalled", got.size(), 0);
		wr_ready <= 1'b1;
		wait_idle();
		chk("page count", got.size(), 8);
		for (int k = 0; k < 8; k++)
			chk("page byte", got.pop_front(),
				{9'h007, 8'(8'hfe + k), 8'(8'h12 + k)});
		chk("page addr", cur_addr, 17'h00706);
	endtask
	task automatic t_protect();
		logic [11:0] nk;
		@(posedge clk);
		wp <= 1'b1;
		frame({TC, 4'b1100}, 16'h0100, 3, 8'h00, nk);
		chk("wp acks", nk[3:0], 4'h0);
		repeat (10) @(posedge clk);
		chk("wp no commit", commits, 2);
		frame({TC, 4'b1100}, 16'h0, 0, 8'h0, nk);
		chk("wp ready", nk[0], 1'b0);
		chk("wp nothing", got.size(), 0);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		t_decode();
		t_byte();
		t_page();
		t_protect();
		conclude();
	end
	initial begin
		#400000;
		err_count++;
		conclude();
	end
endmodule
bind seaw_ctrl seaw_ctrl_props #(.WCC(WRITE_CYCLE_CYCLES)) u_props (
	.clk(clk), .reset(reset), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .wr_addr(wr_addr), .wr_valid(wr_valid),
	.wr_commit(wr_commit), .wr_busy(wr_busy));
